/* File: core/bcl_loader.sv */
// Purpose: Boot loader FSM reading config block and firmware header
// Assumes: Memory answers mem_valid_in some cycles after mem_req_out
// Notes: Recovery command handling itself lives outside this block
`timescale 1ns/1ps
// Function
// - Fetch the configuration block from bytes 0004h to 001Fh after reset.
// - Check signature bytes at offsets 4 and 5 equal E3h and 8Eh.
// - Check offsets 6 and 7 equal 1Ch and 71h, the complements.
// - Read two-byte header address from offset 12.
// - Take only clock-out, external I/O, A15 bits from offset 14.
// - Load bus, I/O zone, pin alternate config from 16, 18, 24.
// - Zone 0 config from offset 20, width bit from strap pin.
// - Boot zone config from offset 22, width bit forced 16-bit.
// - Entries are 16-bit slots stepped two bytes apart.
// - No checksum is taken over the configuration block.
// - Header must start with 33h, CCh; both verified.
// - Firmware size at header offset 2, header excluded.
// - Header plus code must sum to zero; offset 3 balances it.
// - Crisis routine label at header offset 4; FFFFh means absent.
// - Entry point label at header offset 6.
// - Size zero or FFh makes the header invalid.
// - Size counts units of 256 bytes.
// - Labels become byte addresses by shifting left one bit.
// - On corrupt firmware, raise recovery mode so the host port can send recovery commands.
// - Bad configuration signature enters external memory failure path.
// - Bad checksum enters firmware failure path, flags, awaits host.
module bcl_loader (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic bus_width_strap_in,
   output logic mem_req_out,
   output logic [15:0] mem_addr_out,
   input wire logic mem_valid_in,
   input wire logic [7:0] mem_data_in,
   output logic [15:0] module_config_reg_out,
   output logic [15:0] bus_interface_config_out,
   output logic [15:0] io_zone_config_out,
   output logic [15:0] static_zone0_config_out,
   output logic [15:0] boot_zone_config_out,
   output logic [15:0] pin_alt_function_enable_out,
   output logic [16:0] entry_addr_out,
   output logic [16:0] crisis_addr_out,
   output logic crisis_present_out,
   output logic boot_ok_out,
   output logic recovery_mode_out,
   output logic [7:0] fail_status_out
);
   typedef enum {
      S_CFG, S_CFG_WAIT, S_HDR, S_HDR_WAIT, S_CODE, S_CODE_WAIT,
      S_CHECK, S_DONE, S_FAIL
   } bcl_state_e;

   bcl_state_e state;
   logic strap_s1, strap_s2;
   logic [4:0] cfg_ofs;
   logic [7:0] lo_byte;
   logic [15:0] hdr_base;
   logic [3:0] hdr_ofs;
   logic [7:0] fw_size;
   logic [15:0] code_left;
   logic [15:0] code_addr;
   logic hdr_sig_ok;
   logic [15:0] crisis_lbl;
   logic [15:0] entry_lbl;
   logic sum_clear, sum_add, sum_zero;
   logic [15:0] word;

   assign word = {mem_data_in, lo_byte};

   // Signature byte test; offsets outside 4 to 7 never fail
   function automatic logic sig_bad(input logic [4:0] ofs,
         input logic [7:0] data);
      sig_bad = (ofs == bcl_pkg::OFS_SIG0 && data != bcl_pkg::SIG0) ||
                (ofs == bcl_pkg::OFS_SIG1 && data != bcl_pkg::SIG1) ||
                (ofs == bcl_pkg::OFS_SIG2 && data != bcl_pkg::SIG2) ||
                (ofs == bcl_pkg::OFS_SIG3 && data != bcl_pkg::SIG3);
   endfunction

   // Header acceptance, shared by sequencer and outcome flags
   function automatic logic hdr_valid(input logic sig_ok,
         input logic sum_ok, input logic [7:0] size);
      hdr_valid = sig_ok && sum_ok && size != 8'h00 &&
                  size != bcl_pkg::SIZE_BAD;
   endfunction

   // Strap pin is asynchronous to the core clock
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
      end else begin
         strap_s1 <= bus_width_strap_in;
         strap_s2 <= strap_s1;
      end
   end

   // Checksum over header and code only, never over config block
   assign sum_clear = (state == S_CFG);
   assign sum_add = mem_valid_in &&
                    (state == S_HDR_WAIT || state == S_CODE_WAIT);

   bcl_sum u_sum (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .clear_in(sum_clear),
      .add_in(sum_add),
      .byte_in(mem_data_in),
      .zero_out(sum_zero)
   );

   // Main sequencer; one outstanding read at a time
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= S_CFG;
         cfg_ofs <= bcl_pkg::OFS_SIG0;
         hdr_ofs <= 4'h0;
         code_left <= 16'h0000;
         code_addr <= 16'h0000;
         mem_req_out <= 1'b0;
         mem_addr_out <= 16'h0000;
      end else begin
         mem_req_out <= 1'b0;
         unique case (state)
            S_CFG: begin
               mem_req_out <= 1'b1;
               mem_addr_out <= {11'h000, cfg_ofs};
               state <= S_CFG_WAIT;
            end
            S_CFG_WAIT: begin
               if (mem_valid_in) begin
                  if (sig_bad(cfg_ofs, mem_data_in)) begin
                     state <= S_FAIL;
                  end else if (cfg_ofs == bcl_pkg::CFG_LAST[4:0]) begin
                     state <= S_HDR;
                  end else begin
                     cfg_ofs <= cfg_ofs + 5'd1;
                     state <= S_CFG;
                  end
               end
            end
            S_HDR: begin
               mem_req_out <= 1'b1;
               mem_addr_out <= hdr_base + {12'h000, hdr_ofs};
               state <= S_HDR_WAIT;
            end
            S_HDR_WAIT: begin
               if (mem_valid_in) begin
                  if (hdr_ofs == bcl_pkg::HDR_LEN - 4'h1) begin
                     code_addr <= hdr_base + {12'h000, bcl_pkg::HDR_LEN};
                     code_left <= {fw_size, 8'h00};
                     // Bad sizes skip the code sweep; the check fails them
                     state <= (fw_size == 8'h00 ||
                               fw_size == bcl_pkg::SIZE_BAD) ?
                              S_CHECK : S_CODE;
                  end else begin
                     hdr_ofs <= hdr_ofs + 4'h1;
                     state <= S_HDR;
                  end
               end
            end
            S_CODE: begin
               mem_req_out <= 1'b1;
               mem_addr_out <= code_addr;
               state <= S_CODE_WAIT;
            end
            S_CODE_WAIT: begin
               if (mem_valid_in) begin
                  code_addr <= code_addr + 16'h0001;
                  code_left <= code_left - 16'h0001;
                  state <= (code_left == 16'h0001) ? S_CHECK : S_CODE;
               end
            end
            S_CHECK: begin
               if (hdr_valid(hdr_sig_ok, sum_zero, fw_size)) begin
                  state <= S_DONE;
               end else begin
                  state <= S_FAIL;
               end
            end
            S_DONE: state <= S_DONE;
            S_FAIL: state <= S_FAIL;
         endcase
      end
   end

   // Config entries captured as 16-bit slots, low byte first
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         lo_byte <= 8'h00;
         hdr_base <= 16'h0000;
         module_config_reg_out <= 16'h0000;
         bus_interface_config_out <= 16'h0000;
         io_zone_config_out <= 16'h0000;
         static_zone0_config_out <= 16'h0000;
         boot_zone_config_out <= 16'h0000;
         pin_alt_function_enable_out <= 16'h0000;
      end else if (state == S_CFG_WAIT && mem_valid_in) begin
         if (!cfg_ofs[0]) begin
            lo_byte <= mem_data_in;
         end else begin
            unique case (cfg_ofs & ~5'h01)
               bcl_pkg::OFS_HDR_PTR: hdr_base <= word;
               bcl_pkg::OFS_MODULE_CONFIG_REG: begin
                  module_config_reg_out <= word & bcl_pkg::MC_KEEP;
                  module_config_reg_out[bcl_pkg::MC_EXM16] <= strap_s2;
               end
               bcl_pkg::OFS_BUS_INTERFACE_CONFIG: bus_interface_config_out <= word;
               bcl_pkg::OFS_IO_ZONE_CONFIG: io_zone_config_out <= word;
               bcl_pkg::OFS_SZ0: begin
                  static_zone0_config_out <= word;
                  static_zone0_config_out[bcl_pkg::BW_BIT] <= strap_s2;
               end
               bcl_pkg::OFS_SZ1: begin
                  boot_zone_config_out <= word;
                  boot_zone_config_out[bcl_pkg::BW_BIT] <= 1'b1;
               end
               bcl_pkg::OFS_PALT: pin_alt_function_enable_out <= word;
               default: ;
            endcase
         end
      end
   end

   // Header fields
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         hdr_sig_ok <= 1'b1;
         fw_size <= 8'h00;
         crisis_lbl <= bcl_pkg::LABEL_NONE;
         entry_lbl <= 16'h0000;
      end else if (state == S_HDR_WAIT && mem_valid_in) begin
         unique case (hdr_ofs)
            bcl_pkg::HOFS_SIG0: begin
               hdr_sig_ok <= (mem_data_in == bcl_pkg::HSIG0);
            end
            bcl_pkg::HOFS_SIG1: begin
               hdr_sig_ok <= hdr_sig_ok &&
                             (mem_data_in == bcl_pkg::HSIG1);
            end
            bcl_pkg::HOFS_SIZE: fw_size <= mem_data_in;
            bcl_pkg::HOFS_CRIS_LO: crisis_lbl[7:0] <= mem_data_in;
            bcl_pkg::HOFS_CRIS_HI: crisis_lbl[15:8] <= mem_data_in;
            bcl_pkg::HOFS_ENTRY_LO: entry_lbl[7:0] <= mem_data_in;
            bcl_pkg::HOFS_ENTRY_HI: entry_lbl[15:8] <= mem_data_in;
            default: ;
         endcase
      end
   end

   // Final outcome outputs
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         boot_ok_out <= 1'b0;
         recovery_mode_out <= 1'b0;
         fail_status_out <= 8'h00;
         entry_addr_out <= 17'h00000;
         crisis_addr_out <= 17'h00000;
         crisis_present_out <= 1'b0;
      end else if (state == S_CHECK) begin
         entry_addr_out <= {entry_lbl, 1'b0};
         crisis_addr_out <= {crisis_lbl, 1'b0};
         crisis_present_out <= (crisis_lbl != bcl_pkg::LABEL_NONE);
         boot_ok_out <= hdr_valid(hdr_sig_ok, sum_zero, fw_size);
         if (!hdr_valid(hdr_sig_ok, sum_zero, fw_size)) begin
            fail_status_out <= bcl_pkg::ST_FAIL_FW;
            recovery_mode_out <= 1'b1;
         end
      end else if (state == S_CFG_WAIT && mem_valid_in &&
                   sig_bad(cfg_ofs, mem_data_in)) begin
         fail_status_out <= bcl_pkg::ST_FAIL_EXT;
         recovery_mode_out <= 1'b1;
      end
   end

   // Boot success and recovery never both shown
   property p_exclusive;
      @(posedge mclk_in) disable iff (reset_in)
         !(boot_ok_out && recovery_mode_out);
   endproperty
   a_exclusive: assert property (p_exclusive)
      else $error("boot ok and recovery both set");

   property p_cfg_range;
      @(posedge mclk_in) disable iff (reset_in)
         (mem_req_out && state == S_CFG_WAIT) |->
         (mem_addr_out >= bcl_pkg::CFG_BASE &&
          mem_addr_out <= bcl_pkg::CFG_LAST);
   endproperty
   a_cfg_range: assert property (p_cfg_range)
      else $error("config fetch outside block");

   property p_boot_bw;
      @(posedge mclk_in) disable iff (reset_in)
         (state == S_HDR) |-> boot_zone_config_out[bcl_pkg::BW_BIT];
   endproperty
   a_boot_bw: assert property (p_boot_bw)
      else $error("boot zone width not 16-bit");

   property p_order;
      @(posedge mclk_in) disable iff (reset_in)
         (state == S_HDR) |-> (cfg_ofs == bcl_pkg::CFG_LAST[4:0]);
   endproperty
   a_order: assert property (p_order)
      else $error("header started out of order");

   property p_module_config_reg_mask;
      @(posedge mclk_in) disable iff (reset_in)
         (module_config_reg_out & ~16'h000F) == 16'h0000;
   endproperty
   a_module_config_reg_mask: assert property (p_module_config_reg_mask)
      else $error("stray module config bits");

   property p_size_bad;
      @(posedge mclk_in) disable iff (reset_in)
         (state == S_CHECK &&
          (fw_size == 8'h00 || fw_size == bcl_pkg::SIZE_BAD))
         |=> recovery_mode_out && !boot_ok_out;
   endproperty
   a_size_bad: assert property (p_size_bad)
      else $error("bad size accepted");

   property p_sum_bad;
      @(posedge mclk_in) disable iff (reset_in)
         (state == S_CHECK && !sum_zero) |=>
         fail_status_out == bcl_pkg::ST_FAIL_FW;
   endproperty
   a_sum_bad: assert property (p_sum_bad)
      else $error("checksum failure not flagged");

   property p_entry;
      @(posedge mclk_in) disable iff (reset_in)
         (state == S_CHECK) |=> entry_addr_out == {$past(entry_lbl), 1'b0};
   endproperty
   a_entry: assert property (p_entry)
      else $error("entry address not label shifted");

   // Config signature failure latches the external fail code
   property p_sig_fail;
      @(posedge mclk_in) disable iff (reset_in)
         (state == S_CFG_WAIT && mem_valid_in &&
          sig_bad(cfg_ofs, mem_data_in)) |=>
         (state == S_FAIL && fail_status_out == bcl_pkg::ST_FAIL_EXT);
   endproperty
   a_sig_fail: assert property (p_sig_fail)
      else $error("config signature failure not flagged");

   property p_zone0_strap;
      @(posedge mclk_in) disable iff (reset_in)
         (state == S_CFG_WAIT && mem_valid_in &&
          cfg_ofs == (bcl_pkg::OFS_SZ0 | 5'h01)) |=>
         static_zone0_config_out[bcl_pkg::BW_BIT] == $past(strap_s2);
   endproperty
   a_zone0_strap: assert property (p_zone0_strap)
      else $error("zone 0 width bit not from strap");
endmodule

/* File: core/bcl_sum.sv */
// Purpose: Running modulo-256 checksum accumulator
// Assumes: One byte per enable pulse
// Notes: Cleared before each header check
`timescale 1ns/1ps
module bcl_sum (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic clear_in,
   input wire logic add_in,
   input wire logic [7:0] byte_in,
   output logic zero_out
);
   logic [7:0] acc;
   // Accumulate; wraps on purpose
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         acc <= 8'h00;
      end else if (clear_in) begin
         acc <= 8'h00;
      end else if (add_in) begin
         acc <= acc + byte_in;
      end
   end
   assign zero_out = (acc == 8'h00);
endmodule

/* File: dv/bcl_loader_bench.sv */
// Purpose: Self-checking bench for the boot configuration loader
// Assumes: Header at 0020h, one 256-byte code unit when valid
// Notes: Image rebuilt and loader reset before each case
`timescale 1ns/1ps
module bcl_loader_bench;
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   logic strap = 1'b0;
   logic [3:0] lat = 4'h1;
   logic req, valid, c_pres, ok, rec;
   logic [7:0] data, fst;
   logic [15:0] addr, module_config_reg, bus_interface_config, io_zone_config, sz0, sz1, palt, first_a, last_a;
   logic [15:0] rcnt;
   logic [16:0] entry, crisis;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;

   bcl_loader DUT (.mclk_in(mclk_in), .reset_in(reset_in),
      .bus_width_strap_in(strap), .mem_req_out(req), .mem_addr_out(addr),
      .mem_valid_in(valid), .mem_data_in(data),
      .module_config_reg_out(module_config_reg), .bus_interface_config_out(bus_interface_config),
      .io_zone_config_out(io_zone_config), .static_zone0_config_out(sz0),
      .boot_zone_config_out(sz1), .pin_alt_function_enable_out(palt),
      .entry_addr_out(entry), .crisis_addr_out(crisis),
      .crisis_present_out(c_pres), .boot_ok_out(ok),
      .recovery_mode_out(rec), .fail_status_out(fst));
   bcl_mem_model MEM (.mclk_in(mclk_in), .reset_in(reset_in),
      .mem_req_in(req), .mem_addr_in(addr), .lat_in(lat),
      .mem_valid_out(valid), .mem_data_out(data),
      .first_addr_out(first_a), .last_addr_out(last_a),
      .read_cnt_out(rcnt));

   // Clock at 100 ns period
   initial begin
      forever #50 mclk_in = ~mclk_in;
   end

   // Hang guard, well above ten boots of under 1800 cycles each
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk_val(input string nm, input logic [16:0] exp,
         input logic [16:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic put_word(input int ofs, input logic [15:0] w);
      MEM.mem[ofs] = w[7:0]; // Low byte at even address
      MEM.mem[ofs + 1] = w[15:8];
   endtask

   // Image: config block, header at 0020h, code after header
   task automatic build(input int bad_sig, input logic [7:0] hs0,
         input logic [7:0] size, input logic bad_sum,
         input logic [15:0] clab);
      logic [7:0] sum;
      int ncode;
      sum = 8'h00;
      ncode = (size == 8'h01) ? 256 : 0; // Bad sizes are never swept
      for (int i = 0; i < 1024; i++) MEM.mem[i] = 8'h00;
      MEM.mem[4] = 8'hE3;
      MEM.mem[5] = 8'h8E;
      MEM.mem[6] = 8'h1C;
      MEM.mem[7] = 8'h71;
      if (bad_sig >= 0) MEM.mem[4 + bad_sig] = MEM.mem[4 + bad_sig] ^ 8'h01;
      MEM.mem[8] = 8'h16;
      put_word(12, 16'h0020);
      put_word(14, 16'h5A5D);
      put_word(16, 16'h1357);
      put_word(18, 16'h2468);
      put_word(20, 16'hC3B4);
      put_word(22, 16'h1234);
      put_word(24, 16'h0F1E);
      MEM.mem[32] = hs0;
      MEM.mem[33] = 8'hCC;
      MEM.mem[34] = size;
      put_word(36, clab);
      put_word(38, 16'hC123);
      for (int i = 0; i < 256; i++) MEM.mem[40 + i] = 8'(i * 7 + 1);
      for (int i = 32; i < 40 + ncode; i++) sum = sum + MEM.mem[i];
      MEM.mem[35] = 8'h00 - sum + 8'(bad_sum);
   endtask

   // Reset, then wait under a bound for either outcome
   task automatic boot(input logic s, input logic [3:0] l);
      @(posedge mclk_in);
      strap <= s;
      lat <= l;
      reset_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      reset_in <= 1'b0;
      for (int i = 0; i < 5000; i++) begin
         @(negedge mclk_in);
         if (ok === 1'b1 || rec === 1'b1) break;
      end
      if (ok !== 1'b1 && rec !== 1'b1) begin
         error_cnt++;
         $display("ERROR boot_done expected 1 seen 0");
      end
   endtask

   task automatic expect_fail(input logic [7:0] code);
      chk_val("recovery", 17'h00001, 17'(rec));
      chk_val("boot_ok", 17'h00000, 17'(ok));
      chk_val("fail_status", 17'(code), 17'(fst));
   endtask

   initial begin
      // Valid image, 16-bit strap, crisis routine present
      build(-1, 8'h33, 8'h01, 1'b0, 16'h8001);
      boot(1'b1, 4'h1);
      chk_val("first_addr", 17'h00004, 17'(first_a));
      chk_val("read_cnt", 17'd292, 17'(rcnt));
      chk_val("last_addr", 17'h00127, 17'(last_a));
      chk_val("module_config_reg", 17'h0000D, 17'(module_config_reg));
      chk_val("bus_interface_config", 17'h01357, 17'(bus_interface_config));
      chk_val("io_zone_config", 17'h02468, 17'(io_zone_config));
      chk_val("palt", 17'h00F1E, 17'(palt));
      chk_val("zone0", 17'h0C3B4, 17'(sz0));
      chk_val("boot_zone", 17'h012B4, 17'(sz1));
      chk_val("entry", 17'h18246, entry);
      chk_val("crisis", 17'h10002, crisis);
      chk_val("crisis_pres", 17'h00001, 17'(c_pres));
      chk_val("boot_ok", 17'h00001, 17'(ok));
      chk_val("recovery", 17'h00000, 17'(rec));
      // Slow memory, 8-bit strap, no crisis routine
      build(-1, 8'h33, 8'h01, 1'b0, 16'hFFFF);
      boot(1'b0, 4'h3);
      chk_val("module_config_reg", 17'h00005, 17'(module_config_reg));
      chk_val("zone0", 17'h0C334, 17'(sz0));
      chk_val("crisis_pres", 17'h00000, 17'(c_pres));
      chk_val("boot_ok", 17'h00001, 17'(ok));
      // Each configuration signature byte wrong in turn
      for (int k = 0; k < 4; k++) begin
         build(k, 8'h33, 8'h01, 1'b0, 16'hFFFF);
         boot(1'b1, 4'h2);
         expect_fail(8'h01);
      end
      // Header signature, sizes 0 and FFh, checksum off by one
      build(-1, 8'h34, 8'h01, 1'b0, 16'hFFFF);
      boot(1'b1, 4'h1);
      expect_fail(8'h02);
      build(-1, 8'h33, 8'h00, 1'b0, 16'hFFFF);
      boot(1'b1, 4'h1);
      expect_fail(8'h02);
      build(-1, 8'h33, 8'hFF, 1'b0, 16'hFFFF);
      boot(1'b0, 4'h1);
      expect_fail(8'h02);
      build(-1, 8'h33, 8'h01, 1'b1, 16'hFFFF);
      boot(1'b0, 4'h2);
      expect_fail(8'h02);
      stop_test();
   end
endmodule

/* File: dv/bcl_mem_model.sv */
// Purpose: Byte-wide external memory answering loader reads
// Assumes: One read outstanding, latency of at least one cycle
// Notes: Data lines toggle when no answer is due
`timescale 1ns/1ps
module bcl_mem_model (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic mem_req_in,
   input wire logic [15:0] mem_addr_in,
   input wire logic [3:0] lat_in,
   output logic mem_valid_out,
   output logic [7:0] mem_data_out,
   output logic [15:0] first_addr_out,
   output logic [15:0] last_addr_out,
   output logic [15:0] read_cnt_out
);
   logic [7:0] mem [0:1023];
   logic [15:0] addr_q;
   logic [3:0] wait_cnt;
   logic busy;
   logic seen;

   // Read answer after lat_in cycles; lines never hold stale data
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         busy <= 1'b0;
         mem_valid_out <= 1'b0;
         mem_data_out <= 8'h00;
         addr_q <= 16'h0000;
         wait_cnt <= 4'h0;
      end else begin
         mem_valid_out <= 1'b0;
         mem_data_out <= ~mem_data_out; // Inverse pattern while idle
         if (mem_req_in) begin
            busy <= 1'b1;
            addr_q <= mem_addr_in;
            wait_cnt <= lat_in;
         end else if (busy) begin
            if (wait_cnt <= 4'h1) begin
               busy <= 1'b0;
               mem_valid_out <= 1'b1;
               mem_data_out <= mem[addr_q[9:0]]; // Small space, wraps
            end else begin
               wait_cnt <= wait_cnt - 4'h1;
            end
         end
      end
   end

   // Read log kept for the bench: first, last and count
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         seen <= 1'b0;
         first_addr_out <= 16'h0000;
         last_addr_out <= 16'h0000;
         read_cnt_out <= 16'h0000;
      end else if (mem_req_in) begin
         seen <= 1'b1;
         if (!seen) begin
            first_addr_out <= mem_addr_in;
         end
         last_addr_out <= mem_addr_in;
         read_cnt_out <= read_cnt_out + 16'h0001;
      end
   end
endmodule

/* File: pkg/bcl_pkg.sv */
// Purpose: Shared constants for the boot configuration loader
// Assumes: Byte-wide external memory read port
// Notes: Offsets are absolute byte addresses or offsets inside a block
package bcl_pkg;
   localparam int ADDR_W = 16;
   localparam logic [15:0] CFG_BASE = 16'h0004;
   localparam logic [15:0] CFG_LAST = 16'h001F;
   localparam logic [4:0] OFS_SIG0 = 5'h04;
   localparam logic [4:0] OFS_SIG1 = 5'h05;
   localparam logic [4:0] OFS_SIG2 = 5'h06;
   localparam logic [4:0] OFS_SIG3 = 5'h07;
   localparam logic [4:0] OFS_HDR_PTR = 5'h0C;
   localparam logic [4:0] OFS_MODULE_CONFIG_REG = 5'h0E;
   localparam logic [4:0] OFS_BUS_INTERFACE_CONFIG = 5'h10;
   localparam logic [4:0] OFS_IO_ZONE_CONFIG = 5'h12;
   localparam logic [4:0] OFS_SZ0 = 5'h14;
   localparam logic [4:0] OFS_SZ1 = 5'h16;
   localparam logic [4:0] OFS_PALT = 5'h18;
   localparam logic [4:0] ENTRY_STEP = 5'h02;
   localparam logic [7:0] SIG0 = 8'hE3;
   localparam logic [7:0] SIG1 = 8'h8E;
   localparam logic [7:0] SIG2 = 8'h1C;
   localparam logic [7:0] SIG3 = 8'h71;
   localparam logic [7:0] CFG_LEN = 8'h16;
   localparam logic [7:0] HSIG0 = 8'h33;
   localparam logic [7:0] HSIG1 = 8'hCC;
   localparam logic [7:0] SIZE_BAD = 8'hFF;
   localparam logic [15:0] LABEL_NONE = 16'hFFFF;
   localparam logic [3:0] HDR_LEN = 4'h8;
   // Header field offsets
   localparam logic [3:0] HOFS_SIG0 = 4'h0;
   localparam logic [3:0] HOFS_SIG1 = 4'h1;
   localparam logic [3:0] HOFS_SIZE = 4'h2;
   localparam logic [3:0] HOFS_CRIS_LO = 4'h4;
   localparam logic [3:0] HOFS_CRIS_HI = 4'h5;
   localparam logic [3:0] HOFS_ENTRY_LO = 4'h6;
   localparam logic [3:0] HOFS_ENTRY_HI = 4'h7;
   localparam int SIZE_SHIFT = 8;
   // Module config bit positions; bits 0 to 2 from memory, MC_EXM16 from strap
   localparam int MC_CLOCK_OUTPUT_ENABLE = 0;
   localparam int MC_EXTERNAL_IO_ENABLE = 1;
   localparam int MC_ADDR_LINE15_ENABLE = 2;
   localparam int MC_EXM16 = 3;
   localparam logic [15:0] MC_KEEP = 16'h0007;
   localparam int BW_BIT = 7;
   localparam logic [7:0] ST_FAIL_EXT = 8'h01;
   localparam logic [7:0] ST_FAIL_FW = 8'h02;
endpackage
